/* File: common/bisu_pkg.sv */
// Constants for the second interrupt status and mask register block
package bisu_pkg;
  // Register port offset (status read, mask write share it)
  localparam logic [2:0] BISU_OFS_IRQ_SECOND = 3'h2;
  // Bit positions in the status and mask registers
  localparam int BISU_BIT_SUMMARY     = 7;
  localparam int BISU_BIT_SVC_REQ     = 6;
  localparam int BISU_BIT_LOCKOUT     = 5;
  localparam int BISU_BIT_DISTANT     = 4;
  localparam int BISU_BIT_DMA_OUT     = 5;
  localparam int BISU_BIT_DMA_IN      = 4;
  localparam int BISU_BIT_CMD_SENT    = 3;
  localparam int BISU_BIT_LOCKOUT_CHG = 2;
  localparam int BISU_BIT_DISTANT_CHG = 1;
  localparam int BISU_BIT_ADDR_CHG    = 0;
  // Reset value of the mask register
  localparam logic [7:0] BISU_MASK_RST = 8'h00;
  // Width of the first status register enable set (eight pairs)
  localparam int BISU_FIRST_W = 8;
  // Remote/local states
  typedef enum logic [2:0] {
    BISU_LOCS, BISU_LWLS, BISU_REMS, BISU_RWLS
  } bisu_rl_e;
endpackage

/* File: rtl/bisu_irq_upper.sv */
// Upper bits of the second interrupt status register with summary and pin
`timescale 1ns/100ps
module bisu_irq_upper
  import bisu_pkg::*;
#(
  parameter int FIRST_W = BISU_FIRST_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  // Host register port
  input  wire logic [2:0]        i_addr,
  input  wire logic              i_rd,
  input  wire logic              i_wr,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata,
  // First status register flags and their enables
  input  wire logic [FIRST_W-1:0] i_first_status,
  input  wire logic [FIRST_W-1:0] i_first_enable,
  // Lower second-register event flags (command out, lockout chg, remote chg, addr chg)
  input  wire logic [3:0]        i_lower_status,
  // Controller and bus messages (same clock domain)
  input  wire logic              i_cic,
  input  wire logic              i_srq,
  input  wire logic              i_rqs,
  input  wire logic              i_dav,
  // Remote/local inputs
  input  wire logic              i_ren,
  input  wire logic              i_listen_addr,
  input  wire logic              i_go_local,
  input  wire logic              i_lockout_cmd,
  // Outputs
  output logic                   o_bus_irq,
  output logic                   o_bus_irq_n,
  output logic                   o_dma_in_enable,
  output logic                   o_dma_out_enable,
  output logic [3:0]             o_lower_enable
);

  // Elaboration check: first register holds eight pairs at most
  if (FIRST_W < 1 || FIRST_W > 8) begin : g_chk
    $error("FIRST_W out of range");
  end

  // Mask register, service flag, edge history and read snapshot
  logic [7:0] mask_q, mask_d;
  logic       svc_q, svc_d;
  logic       cond_a_q, cond_b_q;
  logic       rd_pend_q, rd_pend_d;
  logic [7:0] rdata_q, rdata_d;
  bisu_rl_e   rl_q, rl_d;

  // Enabled-source OR, shared by the summary and its checker
  function automatic logic enabled_any(input logic [7:0] stat,
                                       input logic [7:0] en);
    return |(stat & en);
  endfunction

  // Lockout-state and remote-state decode
  function automatic logic in_lockout(input bisu_rl_e st);
    return (st == BISU_LWLS) || (st == BISU_RWLS);
  endfunction

  function automatic logic in_remote(input bisu_rl_e st);
    return (st == BISU_REMS) || (st == BISU_RWLS);
  endfunction

  // Address decode of the shared port
  wire logic sel_hit  = (i_addr == BISU_OFS_IRQ_SECOND);
  wire logic rd_stat  = i_rd & sel_hit;
  wire logic wr_mask  = i_wr & sel_hit;

  // Service request set conditions; the second only arises with several requesters
  wire logic cond_a   = i_cic & i_srq & ~(i_rqs & i_dav);
  wire logic cond_b   = i_cic & i_srq & i_rqs & i_dav;
  wire logic srq_rise = (cond_a & ~cond_a_q) | (cond_b & ~cond_b_q);

  // Remote/local decoded flags
  wire logic lockout_flag         = in_lockout(rl_q);
  wire logic distant_control_flag = in_remote(rl_q);

  // Summary: lockout and remote flags are status only, never sources
  wire logic [3:0] low_en   = mask_q[3:0];
  wire logic       first_on = enabled_any(8'(i_first_status), 8'(i_first_enable));
  wire logic       lower_on = enabled_any({4'h0, i_lower_status}, {4'h0, low_en});
  wire logic       svc_on   = svc_q & mask_q[BISU_BIT_SVC_REQ];
  wire logic       summary  = first_on | lower_on | svc_on;

  // Mask write; bit seven kept zero, as the host must write it zero
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = {1'b0, i_wdata[6:0]};
    end
  end

  // Service flag: read wins; a set that meets a read is applied afterwards
  always_comb begin
    svc_d = svc_q;
    if (rd_stat) begin
      svc_d = 1'b0;
    end else if (srq_rise | rd_pend_q) begin
      svc_d = 1'b1;
    end
  end

  // Pending set survives back-to-back reads, or it would be lost
  always_comb begin
    rd_pend_d = 1'b0;
    if (rd_stat) begin
      rd_pend_d = srq_rise | rd_pend_q;
    end
  end

  // Remote/local function, independent of mask contents
  always_comb begin
    rl_d = rl_q;
    case (rl_q)
      BISU_LOCS: begin
        if (i_ren & i_listen_addr) begin
          rl_d = BISU_REMS;
        end else if (i_ren & i_lockout_cmd) begin
          rl_d = BISU_LWLS;
        end
      end
      BISU_LWLS: begin
        if (i_ren & i_listen_addr) begin
          rl_d = BISU_RWLS;
        end
      end
      BISU_REMS: begin
        if (i_go_local) begin
          rl_d = BISU_LOCS;
        end else if (i_lockout_cmd) begin
          rl_d = BISU_RWLS;
        end
      end
      BISU_RWLS: begin
        rl_d = rl_q;
      end
      default: begin
        rl_d = BISU_LOCS;
      end
    endcase
    // Dropping the remote enable always returns to local
    if (!i_ren) begin
      rl_d = BISU_LOCS;
    end
  end

  // Read data snapshot of the status register
  always_comb begin
    rdata_d = rdata_q;
    if (rd_stat) begin
      rdata_d = {summary, svc_q, lockout_flag, distant_control_flag, i_lower_status};
    end
  end

  // State registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      mask_q    <= BISU_MASK_RST;
      svc_q     <= 1'b0;
      cond_a_q  <= 1'b0;
      cond_b_q  <= 1'b0;
      rd_pend_q <= 1'b0;
      rdata_q   <= 8'h00;
      rl_q      <= BISU_LOCS;
    end else begin
      mask_q    <= mask_d;
      svc_q     <= svc_d;
      cond_a_q  <= cond_a;
      cond_b_q  <= cond_b;
      rd_pend_q <= rd_pend_d;
      rdata_q   <= rdata_d;
      rl_q      <= rl_d;
    end
  end

  // Output drive; pin polarity choice left to the host side
  assign o_rdata          = rdata_q;
  assign o_bus_irq        = summary;
  assign o_bus_irq_n      = ~summary;
  assign o_dma_in_enable  = mask_q[BISU_BIT_DMA_IN];
  assign o_dma_out_enable = mask_q[BISU_BIT_DMA_OUT];
  assign o_lower_enable   = mask_q[3:0];

  // Pin follows the enabled sources; lockout and remote add nothing
  a_irq_follows_sum: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_bus_irq == (enabled_any(8'(i_first_status), 8'(i_first_enable))
      | enabled_any({4'h0, i_lower_status}, {4'h0, mask_q[3:0]})
      | (svc_q & mask_q[BISU_BIT_SVC_REQ]))
  ) else $error("interrupt pin does not match enabled sources");

  // Both pin senses are always offered, never equal
  a_pin_inverse: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_bus_irq_n != o_bus_irq
  ) else $error("active-low pin not the inverse of the summary");

  // Summary has no mask of its own: all enables clear means quiet
  a_summary_no_mask: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_first_enable == '0 && mask_q[3:0] == 4'h0 && !mask_q[BISU_BIT_SVC_REQ]) |-> !o_bus_irq
  ) else $error("summary raised with every enable clear");

  // Lockout and remote flags stay out of the summary
  a_lockout_no_irq: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (lockout_flag && !first_on && !lower_on && !svc_on) |-> !o_bus_irq
  ) else $error("lockout state reached the interrupt pin");

  // Service flag: a rising condition outside a read sets it
  a_svc_sets_rise: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (srq_rise && !rd_stat) |=> svc_q
  ) else $error("service flag not set on rising request");

  // Only a controller in charge may raise the service flag
  a_svc_needs_cic: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!i_cic && !svc_q && !rd_pend_q) |=> !svc_q
  ) else $error("service flag set while not in charge");

  // A status read clears the service flag on the next edge
  a_svc_read_clr: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_stat |=> !svc_q
  ) else $error("service flag not cleared by status read");

  // A set meeting a read is parked, then lands once reads stop
  a_svc_pend_taken: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_stat && srq_rise) |=> rd_pend_q
  ) else $error("set during read was not parked");

  a_svc_pend_lands: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_pend_q && !rd_stat) |=> svc_q
  ) else $error("parked set was lost");

  // Mask writes leave the service flag alone
  a_status_no_mask: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (wr_mask && !rd_stat && !srq_rise && !rd_pend_q) |=> svc_q == $past(svc_q)
  ) else $error("mask write disturbed the service flag");

  // Lockout flag follows the lockout states
  a_lockout_state: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    lockout_flag == ((rl_q == BISU_LWLS) || (rl_q == BISU_RWLS))
  ) else $error("lockout flag wrong for state");

  // Read snapshot carries the lockout and remote flags of the read edge
  a_lockout_snap: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_stat |=> o_rdata[BISU_BIT_LOCKOUT] == $past(lockout_flag)
  ) else $error("lockout flag missing from read data");

  a_distant_snap: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_stat |=> o_rdata[BISU_BIT_DISTANT] == $past(distant_control_flag)
  ) else $error("remote flag missing from read data");

  // Enabled and addressed as listener: remote on the next edge
  a_distant_enter: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_ren && i_listen_addr && !distant_control_flag) |=> distant_control_flag
  ) else $error("remote state not entered");

  // Mask write reaches the DMA controls and keeps bit seven zero
  a_dma_in_wr: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    wr_mask |=> o_dma_in_enable == $past(i_wdata[BISU_BIT_DMA_IN])
  ) else $error("DMA input enable not written");

  a_dma_out_wr: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    wr_mask |=> o_dma_out_enable == $past(i_wdata[BISU_BIT_DMA_OUT])
  ) else $error("DMA output enable not written");

  a_mask_top_zero: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    wr_mask |=> !mask_q[BISU_BIT_SUMMARY]
  ) else $error("mask bit seven not held at zero");

endmodule

/* File: dv/bisu_host_model.sv */
// Host processor model for the status/mask register port
`timescale 1ns/100ps
module bisu_host_model
  import bisu_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_rdata,
  output logic [2:0]      o_addr = 3'h0,
  output logic            o_rd = 1'b0,
  output logic            o_wr = 1'b0,
  output logic [7:0]      o_wdata = 8'h00
);
  // Mask write; unused top bit always sent as zero
  task automatic wr_mask(input logic [7:0] d);
    @(negedge i_core_clk);
    o_addr = BISU_OFS_IRQ_SECOND;
    o_wdata = {1'b0, d[6:0]};
    o_wr = 1'b1;
    @(negedge i_core_clk);
    o_wr = 1'b0;
    o_wdata = ~o_wdata; // Released data must not look held
  endtask
  // Status read; snapshot is valid one cycle after the strobe
  task automatic rd_status(output logic [7:0] q);
    @(negedge i_core_clk);
    o_addr = BISU_OFS_IRQ_SECOND;
    o_rd = 1'b1;
    @(negedge i_core_clk);
    o_rd = 1'b0;
    q = i_rdata;
  endtask
endmodule

/* File: dv/bisu_irq_upper_tb.sv */
// Self-checking bench for the upper second interrupt status bits
`timescale 1ns/100ps
module bisu_irq_upper_tb;
  typedef struct packed {logic [7:0] fs, fe; logic [3:0] lo; logic [7:0] mk, ex;} bisu_row_s;
  logic       i_core_clk = 1'b0, i_rstn = 1'b0, i_rd, i_wr, o_bus_irq, o_bus_irq_n;
  logic       i_cic = 1'b0, i_srq = 1'b0, i_rqs = 1'b0, i_dav = 1'b0, i_ren = 1'b0;
  logic       i_listen_addr = 1'b0, i_go_local = 1'b0, i_lockout_cmd = 1'b0;
  logic       o_dma_in_enable, o_dma_out_enable;
  logic [2:0] i_addr;
  logic [3:0] i_lower_status = 4'h0, o_lower_enable;
  logic [7:0] i_wdata, o_rdata, v, outs, i_first_status = 8'h00, i_first_enable = 8'h00;
  int         fail_count = 0, checks = 0;
  // Rows: first status, first enable, lower status, mask, expected pins
  bisu_row_s rows [8] = '{'{8'h01, 8'h01, 4'h0, 8'h00, 8'h80}, '{8'h80, 8'h7f, 4'hf, 8'h00, 8'h40},
    '{8'h00, 8'hff, 4'h5, 8'h01, 8'h81}, '{8'h00, 8'h00, 4'h2, 8'h0d, 8'h4d},
    '{8'h00, 8'h00, 4'h0, 8'h10, 8'h60}, '{8'h00, 8'h00, 4'h0, 8'h20, 8'h50},
    '{8'h00, 8'h00, 4'hf, 8'hff, 8'hbf}, '{8'h00, 8'h00, 4'h8, 8'h08, 8'h88}};
  assign outs = {o_bus_irq, o_bus_irq_n, o_dma_in_enable, o_dma_out_enable, o_lower_enable};
  // Free-running core clock
  always #5 i_core_clk = ~i_core_clk;
  bisu_irq_upper i_bisu_irq_upper (.i_core_clk, .i_rstn, .i_addr, .i_rd, .i_wr, .i_wdata,
    .o_rdata, .i_first_status, .i_first_enable, .i_lower_status, .i_cic, .i_srq, .i_rqs,
    .i_dav, .i_ren, .i_listen_addr, .i_go_local, .i_lockout_cmd, .o_bus_irq, .o_bus_irq_n,
    .o_dma_in_enable, .o_dma_out_enable, .o_lower_enable);
  bisu_host_model i_bisu_host_model (.i_core_clk, .i_rdata(o_rdata), .o_addr(i_addr),
    .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata));
  task automatic chk(input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic rd(input logic [7:0] e);
    i_bisu_host_model.rd_status(v);
    chk(v, e);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence: reset, table rows, then awkward cases
  initial begin
    cyc(20);
    i_rstn = 1'b1;
    chk(outs, 8'h40);
    rd(8'h00);
    foreach (rows[k]) begin
      i_first_status = rows[k].fs;
      i_first_enable = rows[k].fe;
      i_lower_status = rows[k].lo;
      i_bisu_host_model.wr_mask(rows[k].mk);
      cyc(1);
      chk(outs, rows[k].ex);
    end
    i_lower_status = 4'h0;
    i_bisu_host_model.wr_mask(8'h40);
    i_cic = 1'b1;
    i_srq = 1'b1;
    cyc(2);
    chk(outs, 8'h80);
    rd(8'hc0);
    rd(8'h00);
    i_rqs = 1'b1;
    i_dav = 1'b1;
    cyc(2);
    i_bisu_host_model.wr_mask(8'h00);
    chk(outs, 8'h40);
    rd(8'h40);
    i_cic = 1'b0;
    {i_srq, i_rqs, i_dav} = 3'h0;
    cyc(1);
    i_srq = 1'b1;
    cyc(2);
    rd(8'h00);
    i_srq = 1'b0;
    i_cic = 1'b1;
    cyc(1);
    // Set condition rises on the very edge that takes the read
    fork
      i_bisu_host_model.rd_status(v);
      begin
        cyc(1);
        i_srq = 1'b1;
      end
    join
    chk(v, 8'h00);
    rd(8'h40);
    {i_cic, i_srq} = 2'h0;
    i_ren = 1'b1;
    i_listen_addr = 1'b1;
    cyc(1);
    i_listen_addr = 1'b0;
    rd(8'h10);
    i_go_local = 1'b1;
    cyc(1);
    i_go_local = 1'b0;
    rd(8'h00);
    i_listen_addr = 1'b1;
    cyc(1);
    i_listen_addr = 1'b0;
    i_lockout_cmd = 1'b1;
    cyc(1);
    i_lockout_cmd = 1'b0;
    cyc(1);
    chk(outs, 8'h40);
    rd(8'h30);
    i_ren = 1'b0;
    cyc(2);
    rd(8'h00);
    // Lockout entered from local, then remote with lockout
    i_ren = 1'b1;
    i_lockout_cmd = 1'b1;
    cyc(1);
    i_lockout_cmd = 1'b0;
    rd(8'h20);
    i_listen_addr = 1'b1;
    cyc(1);
    i_listen_addr = 1'b0;
    rd(8'h30);
    // Mid-run reset with the service flag set and every mask bit written
    {i_cic, i_srq} = 2'h3;
    i_bisu_host_model.wr_mask(8'h7f);
    cyc(1);
    chk(outs, 8'hbf);
    i_rstn = 1'b0;
    {i_cic, i_srq, i_ren} = 3'h0;
    cyc(2);
    chk(outs, 8'h40);
    i_rstn = 1'b1;
    rd(8'h00);
    tally_and_finish();
  end
endmodule
